// File: hw/sis_pkg.sv
// Package with the constants, field layouts and types of the scan sequencer.
package sis_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_CTRL   = 8'h00; // Enable, restart, clock select.
  localparam logic [7:0] OFF_STATUS = 8'h04; // Sticky events, write 1 clears.
  localparam logic [7:0] OFF_MASK   = 8'h08; // Interrupt mask, same layout.
  localparam logic [7:0] OFF_OUTS   = 8'h0C; // Output bits and current timing state index.
  localparam logic [7:0] OFF_PERIOD = 8'h10; // Sampling period in clk cycles.
  localparam logic [7:0] OFF_REF    = 8'h40; // Sixteen reference words.
  localparam logic [7:0] OFF_TSM    = 8'h80; // Thirty-two timing state words.
  // Control register fields.
  localparam int CTRL_EN      = 0;           // Sequencer enable.
  localparam int CTRL_RESTART = 1;           // Restart at once after a stop.
  localparam int CTRL_CSEL_LO = 2;           // Clock source select, two bits.
  // Status and mask fields.
  localparam int ST_STOP   = 0;              // A cycle has stopped.
  localparam int ST_CHANGE = 1;              // An output bit has changed.
  localparam int ST_W      = 2;              // Number of event bits.
  // Timing state word fields.
  localparam int TS_DUR_LO  = 11;            // Five MSBs give the duration.
  localparam int TS_STOP    = 10;            // Last state of the cycle.
  localparam int TS_CH_LO   = 8;             // Channel number, two bits.
  localparam int TS_EXCITE  = 7;             // Excite the selected sensor.
  localparam int TS_COMPARE = 6;             // Latch comparator at state end.
  localparam int TS_FRONT   = 5;             // 0 first, 1 second front end.
  // Sizes.
  localparam int TSM_N   = 32;               // Number of timing states.
  localparam int REF_N   = 16;               // Reference words, 8 per front.
  localparam int REF_W   = 12;               // Reference converter width.
  localparam int TS_W    = 16;               // Timing state word width.
  localparam int CH_N    = 4;                // Sensor channels.
  localparam int OUT_N   = 8;                // Channel output bits.
  // Reset values.
  localparam logic [3:0]  CTRL_RST   = 4'h0;
  localparam logic [15:0] PERIOD_RST = 16'h0100;
  // Clock source codes.
  localparam logic [1:0] CSEL_LF  = 2'h0;    // Low-frequency clock tick.
  localparam logic [1:0] CSEL_OSC = 2'h1;    // Internal scan oscillator tick.
  localparam logic [1:0] CSEL_SYS = 2'h2;    // Subsystem master clock.
  // Nominal source rates, for reference by software.
  localparam int LF_HZ      = 32768;
  localparam int OSC_MIN_HZ = 2300000;
  localparam int OSC_MAX_HZ = 7900000;
  localparam int CLK_HZ     = 40000000;      // System clock rate.
  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    SIS_IDLE = 3'b001,
    SIS_RUN  = 3'b010,
    SIS_WAIT = 3'b100
  } sis_state_type;
endpackage

// File: hw/sis_ppu_if.sv
// Interface joining the sequencer to its preprocessing unit.
`timescale 1ns/1ps
`default_nettype none
interface sis_ppu_if;
  logic       latch_en;   // Store one comparator result, pulse.
  logic [2:0] latch_idx;  // Output bit that takes the result.
  logic       latch_val;  // Comparator result to store.
  logic       cycle_stop; // End of a measurement cycle, pulse.
  logic [7:0] out_bits;   // Stored channel output bits.
  logic [7:0] psm_data;   // Results handed to the processing machine.
  logic       psm_start;  // Start of evaluation, pulse.
  logic       changed;    // Some output bit changed, pulse.
  modport seq (output latch_en, latch_idx, latch_val, cycle_stop,
               input out_bits, psm_data, psm_start, changed);
  modport ppu (input latch_en, latch_idx, latch_val, cycle_stop,
               output out_bits, psm_data, psm_start, changed);
endinterface
`default_nettype wire

// File: hw/sis_preproc.sv
// Preprocessing unit: stores comparator results and forwards each cycle.
`timescale 1ns/1ps
`default_nettype none
module sis_preproc (
  input  wire logic clk,
  input  wire logic rstn,
  sis_ppu_if.ppu    pif
);
  logic [7:0] bits_q, bits_d;  // One result register per output bit.
  logic [7:0] data_q, data_d;  // Snapshot for the processing machine.
  logic       start_q, start_d;
  logic       chg_q, chg_d;

  // Next values; a result latched in the stop cycle joins that snapshot.
  always_comb begin
    bits_d = bits_q;
    if (pif.latch_en) begin
      bits_d[pif.latch_idx] = pif.latch_val;
    end
    chg_d   = pif.latch_en && (bits_d != bits_q);
    data_d  = pif.cycle_stop ? bits_d : data_q;
    start_d = pif.cycle_stop;
  end

  // Registers; history stays between cycles for the hysteresis choice.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bits_q  <= 8'h00;
      data_q  <= 8'h00;
      start_q <= 1'b0;
      chg_q   <= 1'b0;
    end else begin
      bits_q  <= bits_d;
      data_q  <= data_d;
      start_q <= start_d;
      chg_q   <= chg_d;
    end
  end

  assign pif.out_bits  = bits_q;
  assign pif.psm_data  = data_q;
  assign pif.psm_start = start_q;
  assign pif.changed   = chg_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_store;
    pif.latch_en |=> bits_q[$past(pif.latch_idx)] == $past(pif.latch_val);
  endproperty
  a_store: assert property (p_store)
    else $error("Comparator result not stored.");

  property p_forward;
    pif.cycle_stop |=> start_q && data_q == bits_q ##1 !start_q;
  endproperty
  a_forward: assert property (p_forward)
    else $error("Results not forwarded on stop.");

  property p_hold;
    !pif.latch_en |=> $stable(bits_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Output history lost.");
endmodule
`default_nettype wire

// File: hw/scan_interface_sequencer.sv
// Top of the scan sequencer: APB registers, timing machine, references.
`timescale 1ns/1ps
`default_nettype none
module scan_interface_sequencer (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lf_tick,
  input  wire logic        osc_tick,
  input  wire logic        cmp_in,
  output logic [3:0]       excite,
  output logic [11:0]      dac_ref,
  output logic             front_sel,
  output logic             cycle_stop,
  output logic [7:0]       psm_data,
  output logic             psm_start,
  output logic             irq
);
  // Register storage; the arrays are small enough for flops.
  logic [15:0] tsm_q [sis_pkg::TSM_N];   // Timing state words.
  logic [15:0] tsm_d [sis_pkg::TSM_N];
  logic [11:0] ref_q [sis_pkg::REF_N];   // Reference words.
  logic [11:0] ref_d [sis_pkg::REF_N];
  logic [3:0]  ctrl_q, ctrl_d;           // Control bits.
  logic [1:0]  stat_q, stat_d;           // Sticky events.
  logic [1:0]  mask_q, mask_d;           // Interrupt mask.
  logic [15:0] per_q, per_d;             // Sampling period.
  logic [31:0] rd_q, rd_d;               // Read data register.
  logic        rdy_q, rdy_d;             // Ready register.
  logic        err_q, err_d;             // Error register.
  logic        irq_q, irq_d;             // Interrupt register.
  // Sequencer state.
  sis_pkg::sis_state_type st_q, st_d;    // Machine state.
  logic [4:0]  idx_q, idx_d;             // Current timing state.
  logic [4:0]  dur_q, dur_d;             // Ticks spent in the state.
  logic [15:0] wcnt_q, wcnt_d;           // Cycles waited for the period.
  logic [3:0]  exc_q, exc_d;             // Sensor excitation.
  logic [11:0] dac_q, dac_d;             // Applied reference.
  logic        fsel_q, fsel_d;           // Front end in use.
  logic        stop_q, stop_d;           // Cycle stop pulse.
  logic        lat_q, lat_d;             // Latch pulse.
  logic [2:0]  lidx_q, lidx_d;           // Latch target bit.
  logic        lval_q, lval_d;           // Latched comparator value.
  // Bus decode, timing and check helpers.
  logic        acc;                      // Access phase of a transfer.
  logic        wr_ok;                    // Write commits this edge.
  logic        tick;                     // Selected timing tick.
  logic [15:0] cur;                      // Word of the current state.
  logic [15:0] nxt;                      // Word of the next state.
  logic [15:0] cur_ref;                  // Helper for the checks.

  sis_ppu_if pif ();

  sis_preproc u_ppu (
    .clk  (clk),
    .rstn (rstn),
    .pif  (pif)
  );

  // Reference index: front end, channel, then last output bit.
  function automatic logic [3:0] ref_index(input logic f,
                                           input logic [1:0] ch,
                                           input logic last);
    ref_index = {f, ch, last};
  endfunction

  // Output bit index of a front end and channel.
  function automatic logic [2:0] out_index(input logic f,
                                           input logic [1:0] ch);
    out_index = {f, ch};
  endfunction

  assign acc   = psel && penable;
  assign wr_ok = acc && rdy_q && pwrite;
  assign cur   = tsm_q[idx_q];
  assign nxt   = tsm_q[idx_d];

  // Timing tick from the selected source; the system clock ticks always.
  always_comb begin
    case (ctrl_q[sis_pkg::CTRL_CSEL_LO +: 2])
      sis_pkg::CSEL_LF:  tick = lf_tick;
      sis_pkg::CSEL_OSC: tick = osc_tick;
      sis_pkg::CSEL_SYS: tick = 1'b1;
      default:           tick = lf_tick;
    endcase
  end

  // Bus slave next values: one wait state, so ready is a clean flop.
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    per_d  = per_q;
    for (int i = 0; i < sis_pkg::TSM_N; i++) begin
      tsm_d[i] = tsm_q[i];
    end
    for (int i = 0; i < sis_pkg::REF_N; i++) begin
      ref_d[i] = ref_q[i];
    end
    rdy_d = acc && !rdy_q;
    err_d = err_q;
    rd_d  = rd_q;
    if (acc && !rdy_q) begin
      err_d = 1'b0;
      rd_d  = 32'h0000_0000;
      if (paddr[1:0] != 2'h0) begin
        err_d = 1'b1;
      end else if (paddr >= sis_pkg::OFF_TSM) begin
        rd_d = {16'h0000, tsm_q[paddr[6:2]]};
      end else if (paddr >= sis_pkg::OFF_REF) begin
        // Compared as an int: the count of sixteen does not fit four bits.
        if (int'(paddr[5:2]) < sis_pkg::REF_N) begin
          rd_d = {20'h00000, ref_q[paddr[5:2]]};
        end else begin
          err_d = 1'b1;
        end
      end else begin
        case (paddr)
          sis_pkg::OFF_CTRL:   rd_d = {28'h0000000, ctrl_q};
          sis_pkg::OFF_STATUS: rd_d = {30'h00000000, stat_q};
          sis_pkg::OFF_MASK:   rd_d = {30'h00000000, mask_q};
          sis_pkg::OFF_OUTS:   rd_d = {16'h0000, 3'h0, idx_q, pif.out_bits};
          sis_pkg::OFF_PERIOD: rd_d = {16'h0000, per_q};
          default:             err_d = 1'b1;
        endcase
      end
    end
    // Writes land only at the edge where ready is seen high.
    if (wr_ok && !err_q) begin
      if (paddr >= sis_pkg::OFF_TSM) begin
        tsm_d[paddr[6:2]] = pwdata[15:0];
      end else if (paddr >= sis_pkg::OFF_REF) begin
        ref_d[paddr[5:2]] = pwdata[11:0];
      end else begin
        case (paddr)
          sis_pkg::OFF_CTRL:   ctrl_d = pwdata[3:0];
          sis_pkg::OFF_MASK:   mask_d = pwdata[1:0];
          sis_pkg::OFF_PERIOD: per_d  = pwdata[15:0];
          default:             ctrl_d = ctrl_q;
        endcase
      end
    end
    // Sticky events; a new event wins over a clear in the same cycle.
    stat_d = stat_q;
    if (wr_ok && !err_q && paddr == sis_pkg::OFF_STATUS) begin
      stat_d = stat_q & ~pwdata[1:0];
    end
    stat_d[sis_pkg::ST_STOP]   = stat_d[sis_pkg::ST_STOP] | stop_q;
    stat_d[sis_pkg::ST_CHANGE] = stat_d[sis_pkg::ST_CHANGE] | pif.changed;
    irq_d = |(stat_d & mask_d);
  end

  // Bus and register flops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= sis_pkg::CTRL_RST;
      stat_q <= 2'h0;
      mask_q <= 2'h0;
      per_q  <= sis_pkg::PERIOD_RST;
      rd_q   <= 32'h0000_0000;
      rdy_q  <= 1'b0;
      err_q  <= 1'b0;
      irq_q  <= 1'b0;
      for (int i = 0; i < sis_pkg::TSM_N; i++) begin
        tsm_q[i] <= 16'h0000;
      end
      for (int i = 0; i < sis_pkg::REF_N; i++) begin
        ref_q[i] <= 12'h000;
      end
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      per_q  <= per_d;
      rd_q   <= rd_d;
      rdy_q  <= rdy_d;
      err_q  <= err_d;
      irq_q  <= irq_d;
      tsm_q  <= tsm_d;
      ref_q  <= ref_d;
    end
  end

  // Timing machine next values; it alone drives every sequenced part.
  always_comb begin
    st_d   = st_q;
    idx_d  = idx_q;
    dur_d  = dur_q;
    wcnt_d = wcnt_q;
    stop_d = 1'b0;
    lat_d  = 1'b0;
    lidx_d = lidx_q;
    lval_d = lval_q;
    case (st_q)
      sis_pkg::SIS_IDLE: begin
        if (ctrl_q[sis_pkg::CTRL_EN]) begin
          st_d  = sis_pkg::SIS_RUN;
          idx_d = 5'h00;
          dur_d = 5'h00;
        end
      end
      sis_pkg::SIS_RUN: begin
        if (tick) begin
          if (dur_q != cur[sis_pkg::TS_DUR_LO +: 5]) begin
            dur_d = dur_q + 5'h01;
          end else begin
            dur_d = 5'h00;
            // The comparator sees sensor on plus, reference on minus.
            if (cur[sis_pkg::TS_COMPARE]) begin
              lat_d  = 1'b1;
              lidx_d = out_index(cur[sis_pkg::TS_FRONT],
                                 cur[sis_pkg::TS_CH_LO +: 2]);
              lval_d = cmp_in;
            end
            if (cur[sis_pkg::TS_STOP] || idx_q == 5'h1F) begin
              stop_d = 1'b1;
              idx_d  = 5'h00;
              wcnt_d = 16'h0000;
              if (!ctrl_q[sis_pkg::CTRL_RESTART]) begin
                st_d = sis_pkg::SIS_WAIT;
              end
            end else begin
              idx_d = idx_q + 5'h01;
            end
          end
        end
      end
      sis_pkg::SIS_WAIT: begin
        // The period counts system clocks so it holds in any source.
        if (wcnt_q >= per_q) begin
          st_d = sis_pkg::SIS_RUN;
        end else begin
          wcnt_d = wcnt_q + 16'h0001;
        end
      end
      default: begin
        st_d = sis_pkg::SIS_IDLE;
      end
    endcase
    // Clearing enable parks the machine; a pending stop still reports.
    if (!ctrl_q[sis_pkg::CTRL_EN]) begin
      st_d  = sis_pkg::SIS_IDLE;
      idx_d = 5'h00;
      dur_d = 5'h00;
    end
    // Outputs follow the next state so they line up with the index.
    exc_d  = 4'h0;
    fsel_d = nxt[sis_pkg::TS_FRONT];
    if (st_d == sis_pkg::SIS_RUN && nxt[sis_pkg::TS_EXCITE]) begin
      exc_d[nxt[sis_pkg::TS_CH_LO +: 2]] = 1'b1;
    end
    dac_d = ref_q[ref_index(nxt[sis_pkg::TS_FRONT],
                            nxt[sis_pkg::TS_CH_LO +: 2],
                            pif.out_bits[out_index(nxt[sis_pkg::TS_FRONT],
                                nxt[sis_pkg::TS_CH_LO +: 2])])];
  end

  // Timing machine flops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q   <= sis_pkg::SIS_IDLE;
      idx_q  <= 5'h00;
      dur_q  <= 5'h00;
      wcnt_q <= 16'h0000;
      exc_q  <= 4'h0;
      dac_q  <= 12'h000;
      fsel_q <= 1'b0;
      stop_q <= 1'b0;
      lat_q  <= 1'b0;
      lidx_q <= 3'h0;
      lval_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      idx_q  <= idx_d;
      dur_q  <= dur_d;
      wcnt_q <= wcnt_d;
      exc_q  <= exc_d;
      dac_q  <= dac_d;
      fsel_q <= fsel_d;
      stop_q <= stop_d;
      lat_q  <= lat_d;
      lidx_q <= lidx_d;
      lval_q <= lval_d;
    end
  end

  assign pif.latch_en   = lat_q;
  assign pif.latch_idx  = lidx_q;
  assign pif.latch_val  = lval_q;
  assign pif.cycle_stop = stop_q;
  assign prdata    = rd_q;
  assign pready    = rdy_q;
  assign pslverr   = err_q;
  assign excite    = exc_q;
  assign dac_ref   = dac_q;
  assign front_sel = fsel_q;
  assign cycle_stop = stop_q;
  assign psm_data  = pif.psm_data;
  assign psm_start = pif.psm_start;
  assign irq       = irq_q;

  assign cur_ref = {4'h0, ref_q[ref_index(cur[sis_pkg::TS_FRONT],
                    cur[sis_pkg::TS_CH_LO +: 2],
                    pif.out_bits[out_index(cur[sis_pkg::TS_FRONT],
                        cur[sis_pkg::TS_CH_LO +: 2])])]};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_one_excite;
    $onehot0(exc_q);
  endproperty
  a_one_excite: assert property (p_one_excite)
    else $error("More than one sensor excited.");

  property p_idle_quiet;
    !ctrl_q[sis_pkg::CTRL_EN] |=> st_q == sis_pkg::SIS_IDLE && exc_q == 4'h0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("Sequencer active while disabled.");

  property p_dur;
    st_q == sis_pkg::SIS_RUN && tick && ctrl_q[sis_pkg::CTRL_EN]
      && dur_q != cur[sis_pkg::TS_DUR_LO +: 5] |=> $stable(idx_q);
  endproperty
  a_dur: assert property (p_dur)
    else $error("State left before its duration.");

  property p_last_state;
    st_q == sis_pkg::SIS_RUN && tick && ctrl_q[sis_pkg::CTRL_EN]
      && idx_q == 5'h1F && dur_q == cur[sis_pkg::TS_DUR_LO +: 5]
      |=> stop_q;
  endproperty
  a_last_state: assert property (p_last_state)
    else $error("No stop after the last state.");

  property p_after_stop;
    stop_q && ctrl_q[sis_pkg::CTRL_EN] |->
      (ctrl_q[sis_pkg::CTRL_RESTART] ? st_q == sis_pkg::SIS_RUN
                                     : st_q == sis_pkg::SIS_WAIT)
      && idx_q == 5'h00;
  endproperty
  a_after_stop: assert property (p_after_stop)
    else $error("Wrong state after cycle stop.");

  property p_stop_start;
    stop_q |=> psm_start ##1 !psm_start;
  endproperty
  a_stop_start: assert property (p_stop_start)
    else $error("Stop did not start processing.");

  property p_hyst;
    st_q == sis_pkg::SIS_RUN && $stable(idx_q) && !lat_q && !$past(lat_q)
      && $stable(cur_ref) |-> {4'h0, dac_q} == cur_ref;
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("Reference does not follow last output bit.");

  property p_irq;
    ##1 irq_q == |($past(stat_d) & $past(mask_d));
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt does not follow status and mask.");

  c_stop: cover property (stop_q);
  c_restart: cover property (stop_q && ctrl_q[sis_pkg::CTRL_RESTART]);
  c_change: cover property (pif.changed);
  c_wait_done: cover property (st_q == sis_pkg::SIS_WAIT
                               ##1 st_q == sis_pkg::SIS_RUN);
endmodule
`default_nettype wire

// File: verif/sis_sensor_model.sv
// Behavioural model of the four inductor-capacitor sensors and comparator.
`timescale 1ns/1ps
`default_nettype none
module sis_sensor_model (
  input  wire logic        clk,
  input  wire logic [3:0]  excite,
  input  wire logic [11:0] dac_ref,
  input  wire logic        front_sel,
  input  wire logic [95:0] levels,
  output logic             cmp_in
);
  logic [2:0]  idx;   // Output bit served by the excited sensor.
  logic [11:0] lvl;   // Sampled level of that sensor.
  logic        tgl_q = 1'b0; // Noise shown while nothing is excited.

  // An idle comparator input carries no meaning, so it toggles each cycle.
  always_ff @(posedge clk) begin
    tgl_q <= ~tgl_q;
  end

  // Sensor is the plus input and the reference the minus input.
  always_comb begin
    idx = {front_sel, 2'h0};
    for (int c = 0; c < 4; c++) begin
      if (excite[c]) begin
        idx = {front_sel, 2'(c)};
      end
    end
    lvl = levels[12*idx +: 12];
    cmp_in = (excite != 4'h0) ? (lvl > dac_ref) : tgl_q;
  end
endmodule
`default_nettype wire

// File: verif/test_scan_interface_sequencer.sv
// Self-checking testbench of the scan sequencer with its sensor model.
`timescale 1ns/1ps
`default_nettype none
module test_scan_interface_sequencer;
  logic clk, rstn, psel, penable, pwrite, lf_tick, osc_tick, cmp_in;
  logic [7:0]  paddr, psm_data;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, front_sel, cycle_stop, psm_start, irq, er;
  logic [3:0]  excite;
  logic [11:0] dac_ref;
  logic [95:0] lv;               // Sensor levels, eight 12-bit fields.
  logic [11:0] refs [16];        // Reference words as programmed.
  logic [7:0]  last, exq [$];    // Bit history and expected results.
  logic        prev_stop;        // Stop pulse of the cycle before.
  logic        chg;              // Some expected output bit has changed.
  int seed = 73984, n_errors = 0, n_compared = 0, gap = 0, last_gap = 0;

  scan_interface_sequencer dut (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lf_tick(lf_tick),
    .osc_tick(osc_tick), .cmp_in(cmp_in), .excite(excite),
    .dac_ref(dac_ref), .front_sel(front_sel), .cycle_stop(cycle_stop),
    .psm_data(psm_data), .psm_start(psm_start), .irq(irq));
  sis_sensor_model sensor (.clk(clk), .excite(excite), .dac_ref(dac_ref),
    .front_sel(front_sel), .levels(lv), .cmp_in(cmp_in));

  always #12.5 clk = ~clk;

  // Ticks arrive at random so the slower sources see uneven spacing.
  always @(posedge clk) begin
    lf_tick  <= ($random(seed) % 8) == 0;
    osc_tick <= ($random(seed) % 3) == 0;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic ee);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
    chk({nm, "_err"}, {31'h0, ee}, {31'h0, er});
  endtask

  // Expected bits of one cycle; the last bit picks the reference word.
  function automatic logic [7:0] calc();
    logic [7:0] r;
    for (int b = 0; b < 8; b++) begin
      r[b] = lv[12*b +: 12] > refs[b*2 + last[b]];
    end
    if (r != last) chg = 1'b1;
    last = r;
    return r;
  endfunction

  // Push the expected results, then wait for each cycle to be handed on.
  task automatic run(input logic [31:0] ctrl, input int n);
    int t;
    for (int k = 0; k < n; k++) exq.push_back(calc());
    apb(1'b1, sis_pkg::OFF_CTRL, ctrl);
    for (int k = 0; k < n; k++) begin
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (psm_start !== 1'b1 && t < 20000);
      if (t >= 20000) chk("psm_start", 1, 0);
      // Drop restart before the last cycle ends, so no partial cycle runs.
      if (k == n - 2) apb(1'b1, sis_pkg::OFF_CTRL, ctrl & ~32'h2);
    end
    apb(1'b1, sis_pkg::OFF_CTRL, 32'h0);
    lv = {$random(seed), $random(seed), $random(seed)};
  endtask

  // Watches outputs: excitation, stop-to-start order and handed-on data.
  always @(posedge clk) begin
    if (excite !== 4'h0 && !$onehot(excite)) chk("excite", 0, excite);
    if (psm_start === 1'b1) begin
      chk("stop_before_start", 1, prev_stop);
      if (exq.size() == 0) chk("extra_cycle", 0, 1);
      else chk("psm_data", exq.pop_front(), psm_data);
    end
    if (cycle_stop === 1'b1) begin
      last_gap = gap;
      gap = 0;
    end else gap++;
    prev_stop = cycle_stop;
  end

  initial begin
    clk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; last = 8'h00; chg = 1'b0;
    lv = {$random(seed), $random(seed), $random(seed)};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rchk("ctrl", sis_pkg::OFF_CTRL, 32'h0, 1'b0);
    rchk("period", sis_pkg::OFF_PERIOD, 32'h100, 1'b0);
    rchk("unmapped", 8'h14, 32'h0, 1'b1);
    rchk("misaligned", 8'h02, 32'h0, 1'b1);
    for (int i = 0; i < 16; i++) begin
      refs[i] = 12'($random(seed));
      apb(1'b1, sis_pkg::OFF_REF + 8'(4*i), {20'h0, refs[i]});
    end
    rchk("ref5", sis_pkg::OFF_REF + 8'h14, {20'h0, refs[5]}, 1'b0);
    // Eight states, one output bit each, the last one ends the cycle.
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, sis_pkg::OFF_TSM + 8'(4*n), {16'h0, 5'($random(seed) & 7),
          n == 7, 2'(n), 2'b11, n > 3, 5'h00});
    end
    apb(1'b1, sis_pkg::OFF_MASK, 32'h1);
    for (int cs = 0; cs < 4; cs++) run(32'h1 | (cs << 2), 1);
    rchk("outs", sis_pkg::OFF_OUTS, {24'h0, last}, 1'b0);
    rchk("status", sis_pkg::OFF_STATUS, {30'h0, chg, 1'b1}, 1'b0);
    chk("irq_on", 1, irq);
    apb(1'b1, sis_pkg::OFF_STATUS, 32'h3);
    rchk("status_clr", sis_pkg::OFF_STATUS, 32'h0, 1'b0);
    chk("irq_off", 0, irq);
    run(32'h3 | (32'(sis_pkg::CSEL_SYS) << 2), 2);
    chk("restart_gap", 1, last_gap < 256);
    run(32'h1 | (32'(sis_pkg::CSEL_SYS) << 2), 2);
    chk("wait_gap", 1, last_gap > 256);
    repeat (20) @(posedge clk);
    summarize();
  end

  initial begin
    #(25.0 * 80000);
    n_errors++;
    summarize();
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
endmodule
`default_nettype wire
